// ### common/lpc_pkg.sv
// Functional notes
// - CKE low with CS_n high enters power-down.
// - Drive NOP in cycle after power-down entry.
// - Keep CKE high during reads, writes, MRR, MRW.
// - Hold CKE low, then high, tCKE each.
// - Limit power-down time to meet refresh.
// - Exit with CKE high and CS_n high.
// - Wait tXP after CKE high before commands.
// - Two stable clocks before power-down exit.
// - Read: CKE low after RL+RU(tDQSCK)+BL/2+1.
// - Read-AP or MRR: same delay after command.
// - Write: CKE low after WL+1+BL/2+RU(tWR).
// - Write-AP: one cycle more than write.
// - Refresh, activate, precharge: wait tIHCKE.
// - MRW: wait tMRW before CKE low.
// - Deep power-down: CKE low, CS low, CA=011.
// - Deep power-down exit on CKE high, tISCKE.
// - Reinitialise device after deep power-down exit.
// - Clock stop only with refresh executing; the code stops it in power-down, where nothing refreshes.
// - Keep clock 2 cycles around CKE edges.
// - CKE-high frequency change needs 2tCK plus tXP.
package lpc_pkg;
   localparam int TCK_NS       = 100;
   localparam int TCKE_NS      = 15;
   localparam int TXP_NS       = 15;
   localparam int TIHCKE_NS    = 1;
   localparam int TMRW_NS      = 50;
   localparam int TISCKE_NS    = 1;
   localparam int TDQSCK_NS    = 6;
   localparam int TWR_NS       = 15;
   localparam int REFWIN_NS    = 3900;
   localparam int RL_CYC       = 3;
   localparam int WL_CYC       = 1;
   localparam int BL_CYC       = 4;
   localparam int STABLE_CYC   = 2;
   localparam int WRAP_EXTRA   = 1;
   localparam int CAT_EXTRA    = 1;
   function automatic int ru(input int ns);
      int c;
      c = (ns + TCK_NS - 1) / TCK_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int TCKE_CYC   = ru(TCKE_NS);
   localparam int TXP_CYC    = ru(TXP_NS);
   localparam int TIHCKE_CYC = ru(TIHCKE_NS);
   localparam int TMRW_CYC   = ru(TMRW_NS);
   localparam int TISCKE_CYC = ru(TISCKE_NS);
   localparam int RD_CYC     = RL_CYC + ru(TDQSCK_NS) + BL_CYC / 2 + CAT_EXTRA;
   localparam int WR_CYC     = WL_CYC + CAT_EXTRA + BL_CYC / 2 + ru(TWR_NS);
   localparam int WRA_CYC    = WR_CYC + WRAP_EXTRA;
   localparam int PD_MAX_CYC = REFWIN_NS / TCK_NS;
   localparam logic [2:0] CA_DPD = 3'h3;
   localparam logic [2:0] CA_NOP = 3'h7;
   typedef enum logic [2:0] {
      CMD_NONE = 3'h0, CMD_RD = 3'h1, CMD_RDA = 3'h2, CMD_MRR = 3'h3,
      CMD_WR = 3'h4, CMD_WRA = 3'h5, CMD_MRW = 3'h6, CMD_RAP = 3'h7
   } lpc_cmd_type;
   typedef enum logic [2:0] {
      ST_RUN = 3'h0, ST_PD = 3'h1, ST_PDX = 3'h3, ST_DPD = 3'h2,
      ST_DPDX = 3'h6, ST_CLKOFF = 3'h7
   } lpc_state_type;
endpackage

// ### design/lpc_ctrl.sv
`timescale 1ns/100ps
module lpc_ctrl
   import lpc_pkg::*;
(
   // Clock and reset.
   input  wire logic        mclk,
   input  wire logic        rstn,
   // Command observation from the main controller.
   input  wire logic        cmd_valid,
   input  wire lpc_cmd_type cmd_kind,
   input  wire logic        banks_open,
   // Power requests.
   input  wire logic        pd_req,
   input  wire logic        dpd_req,
   input  wire logic        clk_stop_req,
   input  wire logic        wake_req,
   // Status.
   output logic             busy,
   output logic             cmd_ok,
   output logic             active_pd,
   output logic             need_init,
   // Pins toward the memory.
   output logic             cke,
   output logic             cs_n,
   output logic [2:0]       ca,
   output logic             ck_en
);
   // Sequencer state and its counters.
   lpc_state_type state;
   lpc_state_type next_state;
   logic [15:0]   hold;
   logic [15:0]   next_hold;
   logic [15:0]   pd_time;
   logic [15:0]   next_pd_time;
   logic [15:0]   lock;
   logic [15:0]   next_lock;
   logic [15:0]   lock_step;
   logic [15:0]   hold_step;
   logic [15:0]   pd_step;

   // Next values of the pins and flags.
   logic          next_cke;
   logic          next_cs_n;
   logic [2:0]    next_ca;
   logic          next_ck_en;
   logic          next_active_pd;
   logic          next_need_init;

   // Decoded conditions.
   logic          in_run;
   logic          in_pd;
   logic          in_clkoff;
   logic          pd_state;
   logic          hold_done;
   logic          lock_done;
   logic          run_idle;
   logic          moving;
   logic          enter_pd;
   logic          enter_dpd;
   logic          can_low;
   logic          pd_expired;
   logic          leave;
   logic          dpd_wake;
   logic          low_next;
   logic          load_lock;
   logic          clock_parked;
   logic          init_done;
   logic [15:0]   cmd_wait;
   logic [15:0]   hold_load;

   function automatic logic [15:0] wait_of(input lpc_cmd_type k);
      logic [15:0] w;
      w = 16'h0000;
      case (k)
         CMD_RD: begin
            w = 16'(RD_CYC);
         end
         CMD_RDA: begin
            w = 16'(RD_CYC);
         end
         CMD_MRR: begin
            w = 16'(RD_CYC);
         end
         CMD_WR: begin
            w = 16'(WR_CYC);
         end
         CMD_WRA: begin
            w = 16'(WRA_CYC);
         end
         CMD_MRW: begin
            w = 16'(TMRW_CYC);
         end
         CMD_RAP: begin
            w = 16'(TIHCKE_CYC);
         end
         default: begin
            w = 16'h0000;
         end
      endcase
      return w;
   endfunction

   function automatic logic [15:0] hold_of(input lpc_state_type from,
                                           input lpc_state_type to);
      logic [15:0] h;
      h = 16'h0000;
      case (to)
         ST_PD: begin
            if (from == ST_CLKOFF) begin
               h = 16'(STABLE_CYC);
            end else begin
               h = 16'(TCKE_CYC);
            end
         end
         ST_CLKOFF: begin
            h = 16'(STABLE_CYC);
         end
         ST_DPD: begin
            h = 16'(TCKE_CYC);
         end
         ST_PDX: begin
            h = 16'(TCKE_CYC > TXP_CYC ? TCKE_CYC : TXP_CYC);
         end
         ST_DPDX: begin
            h = 16'(TISCKE_CYC);
         end
         default: begin
            h = 16'h0000;
         end
      endcase
      return h;
   endfunction

   // State decodes.
   assign in_run       = (state == ST_RUN);
   assign in_pd        = (state == ST_PD);
   assign in_clkoff    = (state == ST_CLKOFF);
   assign pd_state     = in_pd || in_clkoff;
   assign hold_done    = (hold == 16'h0000);
   assign lock_done    = (lock == 16'h0000);
   assign run_idle     = in_run && hold_done;

   // Lowering CKE waits until every burst and mode access has drained.
   assign cmd_wait     = wait_of(cmd_kind);
   // A shorter drain never cuts a longer one that is already running.
   assign load_lock    = cmd_valid && (cmd_wait > lock);
   assign can_low      = lock_done && !cmd_valid;
   assign enter_pd     = run_idle && (pd_req || clk_stop_req) && can_low;
   assign enter_dpd    = run_idle && dpd_req && can_low;

   // Exit is forced once power-down time reaches the refresh window, as nothing refreshes here.
   assign pd_expired   = (pd_time >= 16'(PD_MAX_CYC));
   assign leave        = (wake_req || pd_expired) && hold_done;
   assign dpd_wake     = wake_req && hold_done;
   assign moving       = (state != next_state);
   assign hold_load    = hold_of(state, next_state);
   assign low_next     = (next_state == ST_PD) ||
                         (next_state == ST_CLKOFF) ||
                         (next_state == ST_DPD);
   // The clock is held stopped only well inside power-down, never at its edges.
   assign clock_parked = in_clkoff && hold_done && !leave;
   assign init_done    = wake_req && in_run && !dpd_req;

   // Next values of the counters.
   assign lock_step    = lock - 16'h0001;
   assign hold_step    = hold - 16'h0001;
   assign pd_step      = pd_time + 16'h0001;
   assign next_lock    = load_lock ? cmd_wait : (lock_done ? 16'h0000 : lock_step);
   assign next_hold    = moving ? hold_load : (hold_done ? 16'h0000 : hold_step);
   assign next_pd_time = pd_state ? pd_step : 16'h0000;

   // Next values of the pins and flags.
   assign next_cke       = !low_next;
   assign next_cs_n      = !enter_dpd;
   assign next_ca        = enter_dpd ? CA_DPD : CA_NOP;
   assign next_ck_en     = !clock_parked;
   assign next_active_pd = enter_pd ? banks_open : active_pd;
   // A new deep power-down entry wins over the init-done strobe.
   assign next_need_init = enter_dpd ? 1'b1 : (init_done ? 1'b0 : need_init);

   always_comb begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (enter_dpd) begin
               next_state = ST_DPD;
            end else if (enter_pd) begin
               next_state = clk_stop_req ? ST_CLKOFF : ST_PD;
            end
         end
         ST_PD: begin
            if (leave) begin
               next_state = ST_PDX;
            end
         end
         ST_CLKOFF: begin
            // Clock resumes before CKE rises so the memory sees stable cycles.
            if (leave) begin
               next_state = ST_PD;
            end
         end
         ST_PDX: begin
            if (hold_done) begin
               next_state = ST_RUN;
            end
         end
         ST_DPD: begin
            if (dpd_wake) begin
               next_state = ST_DPDX;
            end
         end
         ST_DPDX: begin
            if (hold_done) begin
               next_state = ST_RUN;
            end
         end
         default: next_state = ST_RUN;
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         lock <= 16'h0000;
      end else begin
         lock <= next_lock;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         hold <= 16'h0000;
      end else begin
         hold <= next_hold;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pd_time <= 16'h0000;
      end else begin
         pd_time <= next_pd_time;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cke <= 1'b1;
      end else begin
         cke <= next_cke;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cs_n <= 1'b1;
      end else begin
         cs_n <= next_cs_n;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ca <= CA_NOP;
      end else begin
         ca <= next_ca;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ck_en <= 1'b1;
      end else begin
         ck_en <= next_ck_en;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         active_pd <= 1'b0;
      end else begin
         active_pd <= next_active_pd;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         need_init <= 1'b0;
      end else begin
         need_init <= next_need_init;
      end
   end

   assign busy   = !run_idle;
   assign cmd_ok = run_idle && !need_init;
endmodule

// ### bench/lpc_ctrl_checker.sv
`timescale 1ns/100ps
module lpc_ctrl_checker
   import lpc_pkg::*;
(
   // Observed ports.
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic        cmd_valid,
   input wire lpc_cmd_type cmd_kind,
   input wire logic        cmd_ok,
   input wire logic        need_init,
   input wire logic        cke,
   input wire logic        cs_n,
   input wire logic [2:0]  ca,
   input wire logic        ck_en
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   a_entry_code: assert property ($fell(cke) |-> cs_n || ca == CA_DPD)
      else $error("bad entry code");
   a_nop_follows: assert property ($fell(cke) |=> cs_n || ca == CA_NOP)
      else $error("no nop after entry");
   a_exit_cs_high: assert property ($rose(cke) |-> cs_n)
      else $error("exit without cs_n high");
   a_exit_wait: assert property ($rose(cke) |-> !cmd_ok)
      else $error("commands allowed at exit");
   a_read_drain: assert property (cmd_valid && cke && cmd_kind == CMD_RD |=> cke [*7])
      else $error("cke low during read");
   a_write_drain: assert property (cmd_valid && cke && cmd_kind == CMD_WR |=> cke [*5])
      else $error("cke low during write");
   a_clock_stable: assert property ($rose(cke) |-> ck_en && $past(ck_en) && $past(ck_en, 2))
      else $error("clock not stable at exit");
   a_dpd_init: assert property ($fell(cke) && !cs_n |-> ##[0:1] need_init)
      else $error("init flag missing");
endmodule

// ### bench/lpc_mem_model.sv
`timescale 1ns/100ps
module lpc_mem_model (
   // Pins and observed state.
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic       cke,
   input  wire logic       cs_n,
   input  wire logic [2:0] ca,
   input  wire logic       ck_en,
   input  wire logic       banks_open,
   output logic            m_pd,
   output logic            m_dpd,
   output logic            m_act
);
   logic cke_q;
   // A stopped clock gives the die no edge, so nothing is sampled then.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cke_q <= 1'b1;
         m_pd <= 1'b0;
         m_dpd <= 1'b0;
         m_act <= 1'b0;
      end else if (ck_en) begin
         cke_q <= cke;
         if (cke_q && !cke && cs_n) begin
            m_pd <= 1'b1;
            m_act <= banks_open;
         end
         if (cke_q && !cke && !cs_n && ca == 3'h3)
            m_dpd <= 1'b1;
         if (cke) begin
            m_pd <= 1'b0;
            m_dpd <= 1'b0;
         end
      end
   end
endmodule

// ### bench/tb_lpc_ctrl.sv
`timescale 1ns/100ps
`define CK(n, e, s) begin n_compared++; if ((s) !== (e)) begin errors++; \
   $display("unexpected %s exp %0h got %0h", n, e, s); end end
module tb_lpc_ctrl;
   import lpc_pkg::*;
   logic        mclk, rstn, cmd_valid, banks_open, pd_req, dpd_req, clk_stop_req, wake_req;
   logic        busy, cmd_ok, active_pd, need_init, cke, cs_n, ck_en, m_pd, m_dpd, m_act;
   lpc_cmd_type cmd_kind;
   logic [2:0]  ca;
   int          errors, n_compared, cyc, n;
   lpc_ctrl dut (.*);
   lpc_mem_model mem (.*);
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         end_sim();
      end
   end
   task automatic end_sim();
      if (errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wt(input logic v);
      for (n = 0; cke !== v && n < 60; n++) @(negedge mclk);
   endtask
   task automatic rq(input int k);
      @(posedge mclk);
      {pd_req, dpd_req, clk_stop_req} <= 3'(1 << k);
      wt(1'b0);
   endtask
   task automatic t_wake(input logic dp);
      @(posedge mclk);
      {pd_req, dpd_req, clk_stop_req, wake_req} <= 4'h1;
      wt(1'b1);
      `CK("exit cs_n", 1'b1, cs_n)
      `CK("exit ok", 1'b0, cmd_ok)
      `CK("init flag", dp, need_init)
      `CK("exit busy", 1'b1, busy)
      @(posedge mclk);
      wake_req <= 1'b0;
      repeat (2) @(negedge mclk);
      `CK("ready", !dp, cmd_ok)
      `CK("idle", 1'b0, busy)
      if (dp) begin
         @(posedge mclk);
         wake_req <= 1'b1;
         @(posedge mclk);
         wake_req <= 1'b0;
         @(negedge mclk);
         `CK("init done", 1'b1, cmd_ok)
      end
   endtask
   task automatic t_pd(input logic b, input logic w);
      banks_open <= b;
      rq(2);
      `CK("pd cs_n", 1'b1, cs_n)
      @(posedge mclk);
      pd_req <= 1'b0;
      @(negedge mclk);
      `CK("pd kind", {2'b11, b, b}, {m_pd, 1'b1, m_act, active_pd})
      if (w) t_wake(1'b0);
      else begin
         wt(1'b1);
         `CK("pd limit", 1'b1, n <= PD_MAX_CYC + 3)
      end
   endtask
   task automatic t_drain(input lpc_cmd_type k, input int e);
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_kind <= k;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      pd_req <= 1'b1;
      wt(1'b0);
      `CK("drain", 1'b1, n >= e && n <= e + 3)
      t_wake(1'b0);
   endtask
   initial begin
      {rstn, cmd_valid, banks_open, pd_req, dpd_req, clk_stop_req, wake_req} = '0;
      cmd_kind = CMD_NONE;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      t_pd(1'b0, 1'b1);
      t_pd(1'b1, 1'b1);
      t_pd(1'b0, 1'b0);
      t_drain(CMD_RD, RD_CYC);
      t_drain(CMD_RDA, RD_CYC);
      t_drain(CMD_MRR, RD_CYC);
      t_drain(CMD_WR, WR_CYC);
      t_drain(CMD_WRA, WRA_CYC);
      t_drain(CMD_MRW, TMRW_CYC);
      t_drain(CMD_RAP, TIHCKE_CYC);
      rq(1);
      `CK("dpd code", {1'b0, CA_DPD}, {cs_n, ca})
      @(negedge mclk);
      `CK("dpd nop", {2'b11, CA_NOP}, {m_dpd, cs_n, ca})
      t_wake(1'b1);
      rq(0);
      for (n = 0; ck_en !== 1'b0 && n < 9; n++) @(negedge mclk);
      `CK("clock kept", 1'b1, n >= 2)
      t_wake(1'b0);
      end_sim();
   end
endmodule
bind lpc_ctrl lpc_ctrl_checker chk (.*);
